//--- rtl/acc_pkg.sv
// Constants and types for the converter conversion control block.
// Assumes a single 200 MHz clock domain.
`default_nettype none

package acc_pkg;

    // Clock rate
    localparam int CLK_MHZ          = 200;           // Clock in MHz

    // Data widths
    localparam int RESULT_W         = 10;            // Conversion result width
    localparam int THRESH_W         = 8;             // Over-temperature threshold width
    localparam int CHAN_W           = 3;             // Channel select width

    // Channel 0 is the temperature sensor
    localparam logic [2:0] TEMP_CHANNEL = 3'h0;      // Temperature channel code

    // Timing figures as printed, in microseconds
    localparam int VOLT_CONV_US     = 9;             // Voltage conversion, longest
    localparam int TEMP_CONV_US     = 27;            // Temperature conversion, longest
    localparam int POWER_UP_US      = 2;             // Power-up from power-down, longest

    // Pin edge to registered output: two sync flops and output flop, plus one cycle margin
    localparam int PIN_LAT_CYC      = 4;             // Cycles spent before the counters run

    // Cycle counts, longest times rounded down less pin latency, at least one cycle
    localparam int VOLT_CONV_CYC    = (VOLT_CONV_US * CLK_MHZ - PIN_LAT_CYC) < 1 ? 1 :
                                      VOLT_CONV_US * CLK_MHZ - PIN_LAT_CYC;
    localparam int TEMP_CONV_CYC    = (TEMP_CONV_US * CLK_MHZ - PIN_LAT_CYC) < 1 ? 1 :
                                      TEMP_CONV_US * CLK_MHZ - PIN_LAT_CYC;
    localparam int POWER_UP_CYC     = (POWER_UP_US * CLK_MHZ - PIN_LAT_CYC) < 1 ? 1 :
                                      POWER_UP_US * CLK_MHZ - PIN_LAT_CYC;

    // Reset values
    localparam logic       FLAG_RESET     = 1'b1;    // Over-temperature flag idle high
    localparam logic       PDOWN_RESET    = 1'b0;    // Powered up after reset

    // Control states, one-hot
    typedef enum logic [2:0] {
        ACC_IDLE    = 3'b001,                        // Tracking, waiting for start
        ACC_CONVERT = 3'b010,                        // Holding, converting
        ACC_POWERUP = 3'b100                         // Waking from power-down
    } acc_state_type;

endpackage

`default_nettype wire

//--- rtl/acc_sar_core.sv
// Successive-approximation sequencer: one bit decision per step.
// Assumes comparator input is synchronous to mclk_i.
`default_nettype none

module acc_sar_core #(
    parameter int WIDTH = 10                         // Result width
) (
    input  wire logic             mclk_i,            // Clock
    input  wire logic             rst_n_i,           // Synchronised reset, low active
    input  wire logic             start_i,           // Begin approximation
    input  wire logic             step_i,            // Advance one bit
    input  wire logic             comp_i,            // Comparator: input above trial
    output logic [WIDTH-1:0]      trial_o,           // Trial code to the DAC
    output logic [WIDTH-1:0]      result_o           // Final code
);

    // Refuse widths with no bit below the first
    if (WIDTH < 2) begin : g_bad_width
        $error("acc_sar_core: WIDTH too small");
    end

    logic [WIDTH-1:0] code_reg;                      // Accumulated code
    logic [WIDTH-1:0] mask_reg;                      // Bit under trial
    logic [WIDTH-1:0] code_next;                     // Code after decision
    logic [WIDTH-1:0] mask_next;                     // Next bit under trial

    // Keep the trial bit if the comparator says input is above
    assign code_next = comp_i ? (code_reg | mask_reg) : code_reg;
    assign mask_next = mask_reg >> 1;

    ////////////////////////////////////////////////////////////////////////
    // Bit-by-bit approximation
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            code_reg <= '0;
            mask_reg <= '0;
            trial_o  <= '0;
            result_o <= '0;
        end else if (start_i) begin
            code_reg <= '0;
            mask_reg <= {1'b1, {(WIDTH-1){1'b0}}};
            trial_o  <= {1'b1, {(WIDTH-1){1'b0}}};      // Trial mirrors code and mask
        end else if (step_i && (mask_reg != '0)) begin
            code_reg <= code_next;
            mask_reg <= mask_next;
            trial_o  <= code_next | mask_next;          // Registered so the DAC sees no glitch
            result_o <= code_next;
        end
    end

endmodule

`default_nettype wire

//--- rtl/acc_conv_ctrl.sv
// Conversion control: start, track/hold, busy, power-down, over-temperature.
// Assumes host pins are asynchronous; comparator and threshold are on mclk_i.
`default_nettype none

module acc_conv_ctrl #(
    parameter int VOLT_CYC = acc_pkg::VOLT_CONV_CYC, // Voltage conversion cycles
    parameter int TEMP_CYC = acc_pkg::TEMP_CONV_CYC, // Temperature conversion cycles
    parameter int PWR_CYC  = acc_pkg::POWER_UP_CYC   // Power-up cycles
) (
    input  wire logic                             mclk_i,                 // 200 MHz clock
    input  wire logic                             arst_n_i,               // Async reset, low
    input  wire logic                             conversion_start_n_i,   // Start pin
    input  wire logic                             chip_select_n_i,        // Serial select pin
    input  wire logic                             read_write_i,           // High read, low write
    input  wire logic [acc_pkg::CHAN_W-1:0]       channel_i,              // Selected channel
    input  wire logic [acc_pkg::THRESH_W-1:0]     over_temp_threshold_i,  // Threshold value
    input  wire logic                             comp_i,                 // Comparator output
    output logic                                  busy_o,                 // Converting
    output logic                                  hold_o,                 // Track/hold in hold
    output logic                                  power_down_o,           // Part powered down
    output logic                                  over_temp_flag_n_o,     // Over-temp, low
    output logic                                  port_enable_o,          // Serial port active
    output logic [acc_pkg::RESULT_W-1:0]          trial_o,                // Trial code to DAC
    output logic [acc_pkg::RESULT_W-1:0]          result_o                // Last result
);

    localparam int RW = acc_pkg::RESULT_W;            // Result width
    localparam int CW = 15;                           // Step counter width

    // Refuse timings the counter or the bit slicing cannot serve
    if (TEMP_CYC < RW || VOLT_CYC < RW || PWR_CYC < 1 || TEMP_CYC >= (1 << CW)
        || VOLT_CYC >= (1 << CW) || PWR_CYC >= (1 << CW)) begin : g_bad_timing
        $error("acc_conv_ctrl: timing parameters out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    logic [1:0] rst_sync_reg;                         // Reset release pipe
    logic       rst_n;                                // Synchronised reset

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, two flops each, plus a history flop for edges
    logic [1:0] cs_meta_reg;                          // Start pin sync
    logic [1:0] sel_meta_reg;                         // Select pin sync
    logic [1:0] rw_meta_reg;                          // Read/write pin sync
    logic       cs_prev_reg;                          // Start history
    logic       rw_prev_reg;                          // Read/write history

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            cs_meta_reg  <= 2'h3;
            sel_meta_reg <= 2'h3;
            rw_meta_reg  <= 2'h0;
            cs_prev_reg  <= 1'b1;
            rw_prev_reg  <= 1'b0;
        end else begin
            cs_meta_reg  <= {cs_meta_reg[0], conversion_start_n_i};
            sel_meta_reg <= {sel_meta_reg[0], chip_select_n_i};
            rw_meta_reg  <= {rw_meta_reg[0], read_write_i};
            cs_prev_reg  <= cs_meta_reg[1];
            rw_prev_reg  <= rw_meta_reg[1];
        end
    end

    // Edge decode on the synchronised copies
    wire start_lvl  = cs_meta_reg[1];                           // Start level
    wire start_fall = cs_prev_reg & ~start_lvl;                 // Falling start
    wire start_rise = ~cs_prev_reg & start_lvl;                 // Rising start
    wire selected   = ~sel_meta_reg[1];                         // Chip selected
    wire read_end   = ~rw_prev_reg & rw_meta_reg[1] & selected; // Read ends

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    acc_pkg::acc_state_type state_reg;                // Current state
    acc_pkg::acc_state_type state_next;               // Next state
    logic [CW-1:0]          cnt_reg;                  // Cycle counter
    logic [CW-1:0]          cnt_next;                 // Next counter
    logic                   temp_reg;                 // Converting channel 0
    logic                   pdown_reg;                // Powered down
    logic                   pdown_next;               // Next power-down

    // Conversion length by channel
    function automatic logic [CW-1:0] conv_len(input logic is_temp);
        conv_len = is_temp ? CW'(TEMP_CYC) : CW'(VOLT_CYC);
    endfunction

    wire is_temp   = (channel_i == acc_pkg::TEMP_CHANNEL);       // Temperature channel
    wire conv_done = (state_reg == acc_pkg::ACC_CONVERT) && (cnt_reg == CW'(1));
    // One bit decision per RW slices of the conversion time
    wire [CW-1:0] slice    = conv_len(temp_reg) / CW'(RW);       // Cycles per bit
    wire          sar_step = (state_reg == acc_pkg::ACC_CONVERT) && (slice != '0)
                             && ((cnt_reg % slice) == '0);
    wire          sar_go   = (state_reg == acc_pkg::ACC_IDLE) && start_fall && !pdown_reg;

    // Next-state decode
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        pdown_next = pdown_reg;
        case (state_reg)
            acc_pkg::ACC_IDLE: begin
                if (pdown_reg && start_rise) begin                 // Wake up
                    state_next = acc_pkg::ACC_POWERUP;
                    cnt_next   = CW'(PWR_CYC);
                end else if (sar_go) begin                         // Begin
                    state_next = acc_pkg::ACC_CONVERT;
                    cnt_next   = conv_len(is_temp);
                end
            end
            acc_pkg::ACC_CONVERT: begin
                cnt_next = cnt_reg - CW'(1);
                if (conv_done) begin
                    state_next = acc_pkg::ACC_IDLE;
                    pdown_next = ~start_lvl;                       // Sample start
                end
            end
            acc_pkg::ACC_POWERUP: begin
                cnt_next = cnt_reg - CW'(1);
                if (cnt_reg == CW'(1)) begin                       // Awake
                    state_next = acc_pkg::ACC_IDLE;
                    pdown_next = 1'b0;
                end
            end
            default: begin
                state_next = acc_pkg::ACC_IDLE;
                cnt_next   = '0;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= acc_pkg::ACC_IDLE;
            cnt_reg   <= '0;
            pdown_reg <= acc_pkg::PDOWN_RESET;
            temp_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            pdown_reg <= pdown_next;
            if (sar_go) begin
                temp_reg <= is_temp;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit approximation engine
    logic [RW-1:0] sar_result;                        // Result from core

    acc_sar_core #(
        .WIDTH    (RW)
    ) u_sar (
        .mclk_i   (mclk_i),
        .rst_n_i  (rst_n),
        .start_i  (sar_go),
        .step_i   (sar_step),
        .comp_i   (comp_i),
        .trial_o  (trial_o),
        .result_o (sar_result)
    );

    ////////////////////////////////////////////////////////////////////////
    // Over-temperature compare, upper eight bits against threshold
    wire over = sar_result[RW-1 -: acc_pkg::THRESH_W] > over_temp_threshold_i;
    wire trip = conv_done && temp_reg && over;        // Result exceeds

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            busy_o             <= 1'b0;
            hold_o             <= 1'b0;
            power_down_o       <= acc_pkg::PDOWN_RESET;
            over_temp_flag_n_o <= acc_pkg::FLAG_RESET;
            port_enable_o      <= 1'b0;
            result_o           <= '0;
        end else begin
            busy_o        <= (state_next == acc_pkg::ACC_CONVERT);
            hold_o        <= (state_next == acc_pkg::ACC_CONVERT);
            power_down_o  <= pdown_next;
            port_enable_o <= selected;
            if (conv_done) begin
                result_o <= sar_result;
            end
            // Trip wins over a clear in the same cycle; sticky otherwise
            if (trip) begin
                over_temp_flag_n_o <= 1'b0;
            end else if (read_end) begin
                over_temp_flag_n_o <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

//--- verif/acc_ana_model.sv
// Analog front end seen by the converter: held input level and comparator.
// Assumes trial codes settle within one clock cycle.
`default_nettype none
module acc_ana_model (
    input  wire logic [acc_pkg::RESULT_W-1:0] level_i, // Held input, in codes
    input  wire logic [acc_pkg::RESULT_W-1:0] trial_i, // Trial code from DAC
    output logic                              comp_o   // Input above trial
);
    timeunit 1ns;
    timeprecision 1ps;
    // Input sits half a code above level, so an equal trial lies below it
    assign comp_o = (trial_i <= level_i);
endmodule
`default_nettype wire

//--- verif/acc_conv_ctrl_chk.sv
// Checker for conversion control, bound to its top module.
// Assumes channel and threshold stay stable during each conversion.
`default_nettype none
module acc_conv_ctrl_chk #(
    parameter int VOLT_CYC = acc_pkg::VOLT_CONV_CYC, // Voltage conversion cycles
    parameter int TEMP_CYC = acc_pkg::TEMP_CONV_CYC, // Temperature conversion cycles
    parameter int PWR_CYC  = acc_pkg::POWER_UP_CYC   // Power-up cycles
) (
    input wire logic       mclk_i,                // Clock
    input wire logic       arst_n_i,              // Reset, low
    input wire logic       conversion_start_n_i,  // Start pin
    input wire logic       chip_select_n_i,       // Select pin
    input wire logic       read_write_i,          // Read high
    input wire logic [2:0] channel_i,             // Channel
    input wire logic [7:0] over_temp_threshold_i, // Threshold
    input wire logic       busy_o,                // Converting
    input wire logic       hold_o,                // Hold mode
    input wire logic       power_down_o,          // Powered down
    input wire logic       over_temp_flag_n_o,    // Over-temp, low
    input wire logic       port_enable_o,         // Port active
    input wire logic [9:0] result_o               // Result
);
    timeunit 1ns;
    timeprecision 1ps;
    // Wake budget: power-up count plus pin latency
    localparam int WAKE_MAX = PWR_CYC + acc_pkg::PIN_LAT_CYC;
    logic        is_temp;    // Temperature channel selected
    logic [15:0] run_reg;    // Busy cycles so far
    logic [3:0] rd_age_reg; // Cycles since a selected read ended
    logic       rw_reg;     // Read select one cycle back
    assign is_temp = (channel_i == acc_pkg::TEMP_CHANNEL);
    ////////////////////////////////////////////////////////////////////////
    // Helper counters
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_reg    <= 16'h0000;
            rd_age_reg <= 4'hF;
            rw_reg     <= 1'b0;
        end else begin
            run_reg    <= busy_o ? run_reg + 16'h0001 : 16'h0000;
            rd_age_reg <= (read_write_i && !rw_reg && !chip_select_n_i) ? 4'h0 :
                          (rd_age_reg == 4'hF) ? 4'hF : rd_age_reg + 4'h1;
            rw_reg     <= read_write_i;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    property p_hold; hold_o == busy_o; endproperty
    a_hold: assert property (p_hold) else $error("hold differs from busy");
    property p_start;
        $fell(conversion_start_n_i) && !busy_o && !$past(busy_o) && !power_down_o
            && !$past(power_down_o, 10) |-> ##[2:4] busy_o;
    endproperty
    a_start: assert property (p_start) else $error("start edge ignored");
    property p_volt; $fell(busy_o) && !is_temp |-> run_reg <= VOLT_CYC; endproperty
    a_volt: assert property (p_volt) else $error("voltage conversion too long");
    property p_temp; $fell(busy_o) && is_temp |-> run_reg <= TEMP_CYC; endproperty
    a_temp: assert property (p_temp) else $error("temp conversion too long");
    property p_pdown;
        $fell(busy_o) |-> power_down_o == !$past(conversion_start_n_i, 3);
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down wrong");
    property p_set;
        $fell(busy_o) && is_temp && result_o[9:2] > over_temp_threshold_i
            |-> !over_temp_flag_n_o;
    endproperty
    a_set: assert property (p_set) else $error("flag not set");
    property p_sticky; $rose(over_temp_flag_n_o) |-> rd_age_reg <= 4'h6; endproperty
    a_sticky: assert property (p_sticky) else $error("flag left early");
    property p_clear; rd_age_reg == 4'h0 && !busy_o |-> ##[1:5] over_temp_flag_n_o;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");
    property p_sel; $fell(chip_select_n_i) |-> ##[1:4] port_enable_o; endproperty
    a_sel: assert property (p_sel) else $error("port not enabled");
    property p_busy; $rose(busy_o) |-> busy_o [*8]; endproperty
    a_busy: assert property (p_busy) else $error("busy dropped early");
    property p_wake;
        $rose(conversion_start_n_i) && power_down_o |-> ##[1:WAKE_MAX] !power_down_o;
    endproperty
    a_wake: assert property (p_wake) else $error("power-up too slow");
    c_wake: cover property ($fell(power_down_o));
    c_temp: cover property ($fell(busy_o) && is_temp);
    c_pdown: cover property ($rose(power_down_o));
    c_flag: cover property ($fell(over_temp_flag_n_o));
endmodule
bind acc_conv_ctrl acc_conv_ctrl_chk #(
    .VOLT_CYC(VOLT_CYC), .TEMP_CYC(TEMP_CYC), .PWR_CYC(PWR_CYC)) u_chk (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .conversion_start_n_i(conversion_start_n_i),
    .chip_select_n_i(chip_select_n_i), .read_write_i(read_write_i), .channel_i(channel_i),
    .over_temp_threshold_i(over_temp_threshold_i), .busy_o(busy_o), .hold_o(hold_o),
    .power_down_o(power_down_o), .over_temp_flag_n_o(over_temp_flag_n_o),
    .port_enable_o(port_enable_o), .result_o(result_o));
`default_nettype wire

//--- verif/test_acc_conv_ctrl.sv
// Self-checking bench for conversion control with a reference model.
// Assumes short conversion parameters; the bench acts as host.
`default_nettype none
module test_acc_conv_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int VC = 20; // Voltage cycles
    localparam int TC = 40; // Temperature cycles
    localparam int PC = 4;  // Power-up cycles
    logic       mclk, arst_n, start_n, cs_n, rw, comp, busy, hold, pdn, flag_n, pen;
    logic [2:0] ch;
    logic [7:0] thr;
    logic [9:0] trial, result, level;
    logic       exp_flag = 1'b1; // Model of the over-temp flag
    logic [9:0] exp_q[$];        // Expected results, oldest first
    int         n_errors = 0;
    int         compares = 0;
    integer     seed     = 32'h43AE6D5C;
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    acc_conv_ctrl #(.VOLT_CYC(VC), .TEMP_CYC(TC), .PWR_CYC(PC)) DUT (
        .mclk_i(mclk), .arst_n_i(arst_n), .conversion_start_n_i(start_n),
        .chip_select_n_i(cs_n), .read_write_i(rw), .channel_i(ch),
        .over_temp_threshold_i(thr), .comp_i(comp), .busy_o(busy), .hold_o(hold),
        .power_down_o(pdn), .over_temp_flag_n_o(flag_n), .port_enable_o(pen),
        .trial_o(trial), .result_o(result));
    acc_ana_model u_ana (.level_i(level), .trial_i(trial), .comp_o(comp));
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        compares++;
        if (e !== g) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One conversion; stay keeps start high so the part stays powered
    task automatic convert(input logic stay, input logic temp);
        int n;
        logic [9:0] lv; // Level for this conversion
        ch    <= temp ? 3'h0 : 3'(1 + $unsigned($random(seed)) % 4);
        lv    = 10'($random(seed));
        level <= lv;
        exp_q.push_back(lv);
        thr   <= 8'($random(seed));
        tick(1);
        start_n <= 1'b0;
        n = 0;
        while (busy !== 1'b1 && n < 10) begin
            @(posedge mclk);
            #1 n++;
        end
        chk("hold_in_conv", 10'h1, 10'(hold));
        tick(1);
        start_n <= stay;
        tick(3);
        start_n <= 1'b0; // Refused start during conversion
        tick(3);
        start_n <= stay;
        n = 7;
        while (busy === 1'b1 && n < 100) begin
            @(posedge mclk);
            #1 n++;
        end
        chk("busy_len_ok", 10'h1, 10'(n <= (temp ? TC : VC)));
        chk("result", exp_q.pop_front(), result);
        if (temp && level[9:2] > thr) exp_flag = 1'b0;
        chk("flag", 10'(exp_flag), 10'(flag_n));
        chk("power_down", 10'(!stay), 10'(pdn));
        chk("track_after", 10'h0, 10'(hold));
        tick(1);
        start_n <= 1'b1;
        tick(PC + 8);
        #1 chk("powered", 10'h0, 10'(pdn));
    endtask
    // End a read by a rising read select, selected or not
    task automatic read_end(input logic sel);
        tick(1);
        cs_n <= !sel;
        rw   <= 1'b0;
        tick(6);
        #1 chk("port_en", 10'(sel), 10'(pen));
        tick(1);
        rw <= 1'b1;
        tick(6);
        if (sel) exp_flag = 1'b1;
        #1 chk("flag_read", 10'(exp_flag), 10'(flag_n));
        tick(1);
        cs_n <= 1'b1;
        tick(6);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n  = 1'b0;
        start_n = 1'b1;
        cs_n    = 1'b1;
        rw      = 1'b0;
        ch      = 3'h0;
        thr     = 8'h00;
        level   = 10'h000;
        tick(12);
        arst_n <= 1'b1;
        tick(8);
        for (int i = 0; i < 30; i++) begin
            convert(i % 4 != 3, i % 2 == 0);
            if (i % 3 == 0) read_end(i % 2 == 0);
        end
        end_of_test();
    end
    initial begin
        #100000;
        n_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
